// ===== fbp_host.sv
// host controller issuing block protection command sequences to the flash
`timescale 1ns/10ps
`default_nettype none
module fbp_host (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output var  logic [31:0] regRdata,
	output var  logic [23:0] flashAddr,
	output var  logic [15:0] flashDqOut,
	output var  logic        flashDqOe,
	input  wire logic [15:0] flashDqIn,
	output var  logic        flashCeN,
	output var  logic        flashWeN,
	output var  logic        flashOeN
);
	fbp_pkg::fbp_state_t state_r, state_nxt;
	logic [15:0] ctrl_r;
	logic [23:0] addr_r;
	logic [15:0] data_r;
	logic [63:0] pw_r;
	logic [63:0] pwRead_r;
	logic [15:0] rdData_r;
	logic [3:0]  idx_r;
	logic [7:0]  tmr_r;
	logic [7:0]  gap_r;
	logic        busy_r;
	logic        gapRefused_r;
	logic [15:0] dqSync1_r, dqSync2_r;
	fbp_pkg::fbp_cyc_t cyc;
	logic [3:0]  op;
	logic        wide;
	logic [7:0]  code;
	logic [3:0]  seqLen;
	logic        goCmd, lastCyc, tmrDone, isRead, unlockOp;
	logic [3:0]  pwIdx;
	logic [7:0]  pwByte;
	logic [15:0] pwWord;
	logic [11:0] ua1, ua2;

	assign op       = ctrl_r[fbp_pkg::CTRL_OP_LSB +: 4];
	assign wide     = ctrl_r[fbp_pkg::CTRL_WIDE_BIT];
	assign code     = ctrl_r[fbp_pkg::CTRL_CODE_LSB +: 8];
	assign ua1      = wide ? fbp_pkg::UNLK_ADDR1_X16 : fbp_pkg::UNLK_ADDR1_X8;
	assign ua2      = wide ? fbp_pkg::UNLK_ADDR2_X16 : fbp_pkg::UNLK_ADDR2_X8;
	assign unlockOp = (op == fbp_pkg::OP_UNLOCK);
	// unlock is refused by the host itself while the spacing timer runs
	assign goCmd    = regWr && (regAddr == fbp_pkg::REG_CTRL) && !busy_r
	                  && !(regWdata[3:0] == fbp_pkg::OP_UNLOCK && gap_r != 8'h00);
	assign tmrDone  = (tmr_r == 8'h00);
	// password slot of the unlock middle cycles: cycle 2 maps to slot 0
	assign pwIdx    = idx_r - 4'h2;
	assign pwByte   = pw_r[{pwIdx[2:0], 3'b000} +: 8];
	assign pwWord   = pw_r[{pwIdx[1:0], 4'h0} +: 16];

	always_comb begin
		case (op)
			fbp_pkg::OP_ENTER:    seqLen = 4'h3;
			fbp_pkg::OP_EXTEXIT:  seqLen = 4'h4;
			fbp_pkg::OP_EXIT,
			fbp_pkg::OP_PROGRAM,
			fbp_pkg::OP_PWPROG,
			fbp_pkg::OP_CLEARALL: seqLen = 4'h2;
			fbp_pkg::OP_PWREAD:   seqLen = wide ? 4'h4 : 4'h8;
			fbp_pkg::OP_UNLOCK:   seqLen = wide ? 4'h7 : 4'hB;
			default:              seqLen = 4'h1;
		endcase
	end
	assign lastCyc = (idx_r == seqLen - 4'h1);

	always_comb begin
		cyc = '0;
		case (op)
			fbp_pkg::OP_ENTER: begin
				cyc.wr   = 1'b1;
				cyc.addr = {12'h000, (idx_r == 4'h1) ? ua2 : ua1};
				cyc.data = {8'h00, (idx_r == 4'h0) ? fbp_pkg::UNLK_DATA1 :
				           (idx_r == 4'h1) ? fbp_pkg::UNLK_DATA2 : code};
			end
			fbp_pkg::OP_EXTEXIT: begin
				cyc.wr   = 1'b1;
				cyc.addr = (idx_r == 4'h1) ? {12'h000, ua2} : {12'h000, ua1};
				cyc.data = {8'h00, (idx_r == 4'h0) ? fbp_pkg::UNLK_DATA1 :
				           (idx_r == 4'h1) ? fbp_pkg::UNLK_DATA2 :
				           (idx_r == 4'h2) ? fbp_pkg::CMD_EXIT1 : fbp_pkg::CMD_EXIT2};
			end
			fbp_pkg::OP_EXIT: begin
				cyc.wr   = 1'b1;
				cyc.data = {8'h00, (idx_r == 4'h0) ? fbp_pkg::CMD_EXIT1 :
				           fbp_pkg::CMD_EXIT2};
			end
			fbp_pkg::OP_PROGRAM, fbp_pkg::OP_PWPROG: begin
				cyc.wr   = 1'b1;
				cyc.addr = (idx_r == 4'h0) ? 24'h000000 : addr_r;
				cyc.data = (idx_r == 4'h0) ? {8'h00, fbp_pkg::CMD_PROGRAM} : data_r;
			end
			fbp_pkg::OP_CLEARALL: begin
				cyc.wr   = 1'b1;
				cyc.data = {8'h00, (idx_r == 4'h0) ? fbp_pkg::CMD_ERASE1 :
				           fbp_pkg::CMD_ERASE2};
			end
			fbp_pkg::OP_PWREAD: begin
				cyc.addr = {20'h00000, idx_r};
			end
			fbp_pkg::OP_UNLOCK: begin
				cyc.wr = 1'b1;
				if (idx_r == 4'h0) begin
					cyc.data = {8'h00, fbp_pkg::CMD_UNLK1};
				end else if (idx_r == 4'h1) begin
					cyc.data = {8'h00, fbp_pkg::CMD_UNLK2};
				end else if (lastCyc) begin
					cyc.data = {8'h00, fbp_pkg::CMD_UNLK_END};
				end else begin
					cyc.addr = {20'h00000, 1'b0, pwIdx[2:0]};
					cyc.data = wide ? pwWord : {8'h00, pwByte};
				end
			end
			default: begin
				cyc.addr = addr_r;
			end
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			fbp_pkg::ST_IDLE: if (goCmd) state_nxt = fbp_pkg::ST_LOAD;
			fbp_pkg::ST_LOAD: state_nxt = fbp_pkg::ST_ASRT;
			fbp_pkg::ST_ASRT: if (tmrDone) state_nxt = fbp_pkg::ST_DONE;
			fbp_pkg::ST_DONE: state_nxt = lastCyc ? fbp_pkg::ST_WAIT : fbp_pkg::ST_LOAD;
			fbp_pkg::ST_WAIT: if (tmrDone) state_nxt = fbp_pkg::ST_IDLE;
			default:          state_nxt = fbp_pkg::ST_IDLE;
		endcase
	end
	assign isRead = !cyc.wr;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= fbp_pkg::ST_IDLE;
			idx_r   <= 4'h0;
			tmr_r   <= 8'h00;
			busy_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (state_r == fbp_pkg::ST_IDLE && goCmd) begin
				idx_r  <= 4'h0;
				busy_r <= 1'b1;
			end
			if (state_r == fbp_pkg::ST_DONE && !lastCyc)
				idx_r <= idx_r + 4'h1;
			if (state_r == fbp_pkg::ST_LOAD || (state_r == fbp_pkg::ST_DONE && lastCyc))
				tmr_r <= fbp_pkg::BUS_CYC_CNT;
			else if (!tmrDone)
				tmr_r <= tmr_r - 8'h01;
			if (state_r == fbp_pkg::ST_WAIT && tmrDone)
				busy_r <= 1'b0;
		end
	end

	// flash pins, cycle shape: setup in LOAD, strobe in ASRT, release in DONE
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flashAddr  <= 24'h000000;
			flashDqOut <= 16'h0000;
			flashDqOe  <= 1'b0;
			flashCeN   <= 1'b1;
			flashWeN   <= 1'b1;
			flashOeN   <= 1'b1;
		end else begin
			if (state_r == fbp_pkg::ST_LOAD) begin
				flashAddr  <= cyc.addr;
				flashDqOut <= cyc.data;
				flashDqOe  <= cyc.wr;
				flashCeN   <= 1'b0;
			end
			flashWeN <= !(state_r == fbp_pkg::ST_ASRT && cyc.wr && !tmrDone);
			flashOeN <= !(state_r == fbp_pkg::ST_ASRT && isRead);
			if (state_r == fbp_pkg::ST_DONE) begin
				flashCeN  <= 1'b1;
				flashDqOe <= 1'b0;
			end
		end
	end

	// data pins are asynchronous to mclk
	always_ff @(posedge mclk) begin
		dqSync1_r <= flashDqIn;
		dqSync2_r <= dqSync1_r;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdData_r <= 16'h0000;
			pwRead_r <= 64'h0;
		end else if (state_r == fbp_pkg::ST_DONE && isRead) begin
			rdData_r <= dqSync2_r;
			if (op == fbp_pkg::OP_PWREAD) begin
				if (wide)
					pwRead_r[{idx_r[1:0], 4'h0} +: 16] <= dqSync2_r;
				else
					pwRead_r[{idx_r[2:0], 3'b000} +: 8] <= dqSync2_r[7:0];
			end
		end
	end

	// unlock spacing timer starts when an unlock sequence ends
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			gap_r        <= 8'h00;
			gapRefused_r <= 1'b0;
		end else begin
			if (state_r == fbp_pkg::ST_DONE && lastCyc && unlockOp)
				gap_r <= fbp_pkg::UNLK_GAP_CNT;
			else if (gap_r != 8'h00)
				gap_r <= gap_r - 8'h01;
			if (regWr && regAddr == fbp_pkg::REG_CTRL && regWdata[3:0] == fbp_pkg::OP_UNLOCK
			    && gap_r != 8'h00)
				gapRefused_r <= 1'b1;
			else if (goCmd)
				gapRefused_r <= 1'b0;
		end
	end

	// software registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_r <= 16'h0000;
			addr_r <= 24'h000000;
			data_r <= 16'h0000;
			pw_r   <= 64'hFFFFFFFFFFFFFFFF;
		end else if (regWr) begin
			if (goCmd) ctrl_r <= regWdata[15:0];
			if (regAddr == fbp_pkg::REG_ADDR && !busy_r) addr_r <= regWdata[23:0];
			if (regAddr == fbp_pkg::REG_DATA && !busy_r) data_r <= regWdata[15:0];
			if (regAddr == fbp_pkg::REG_PWLO && !busy_r) pw_r[31:0] <= regWdata;
			if (regAddr == fbp_pkg::REG_PWHI && !busy_r) pw_r[63:32] <= regWdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			regRdata <= 32'h00000000;
		end else if (regRd) begin
			case (regAddr)
				fbp_pkg::REG_CTRL:   regRdata <= {16'h0000, ctrl_r};
				fbp_pkg::REG_ADDR:   regRdata <= {8'h00, addr_r};
				fbp_pkg::REG_DATA:   regRdata <= {16'h0000, data_r};
				fbp_pkg::REG_PWLO:   regRdata <= pw_r[31:0];
				fbp_pkg::REG_PWHI:   regRdata <= pw_r[63:32];
				fbp_pkg::REG_STATUS: regRdata <= {30'h0, gapRefused_r, busy_r};
				fbp_pkg::REG_RDATA:  regRdata <= {16'h0000, rdData_r};
				fbp_pkg::REG_PWRLO:  regRdata <= pwRead_r[31:0];
				fbp_pkg::REG_PWRHI:  regRdata <= pwRead_r[63:32];
				default:             regRdata <= 32'h00000000;
			endcase
		end else begin
			regRdata <= 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// ===== fbp_pkg.sv
// package for the flash block protection command controller
package fbp_pkg;
	localparam logic [11:0] UNLK_ADDR1_X8  = 12'hAAA;
	localparam logic [11:0] UNLK_ADDR2_X8  = 12'h555;
	localparam logic [11:0] UNLK_ADDR1_X16 = 12'h555;
	localparam logic [11:0] UNLK_ADDR2_X16 = 12'h2AA;
	localparam logic [7:0]  UNLK_DATA1     = 8'hAA;
	localparam logic [7:0]  UNLK_DATA2     = 8'h55;
	localparam logic [7:0]  CMD_LOCKREG    = 8'h40;
	localparam logic [7:0]  CMD_PASSWORD   = 8'h60;
	localparam logic [7:0]  CMD_NONVOL     = 8'hC0;
	localparam logic [7:0]  CMD_LOCKBIT    = 8'h50;
	localparam logic [7:0]  CMD_VOLATILE   = 8'hE0;
	localparam logic [7:0]  CMD_EXTMEM     = 8'h88;
	localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
	localparam logic [7:0]  CMD_ERASE1     = 8'h80;
	localparam logic [7:0]  CMD_ERASE2     = 8'h30;
	localparam logic [7:0]  CMD_UNLK1      = 8'h25;
	localparam logic [7:0]  CMD_UNLK2      = 8'h03;
	localparam logic [7:0]  CMD_UNLK_END   = 8'h29;
	localparam logic [7:0]  CMD_EXIT1      = 8'h90;
	localparam logic [7:0]  CMD_EXIT2      = 8'h00;
	localparam logic [7:0]  DATA_PROTECT   = 8'h00;
	localparam logic [7:0]  DATA_UNPROTECT = 8'h01;
	localparam logic [7:0]  DATA_PWD_HIDDEN = 8'hFF;
	localparam logic [7:0]  PWD_BYTES_X8   = 8'h08;
	localparam logic [7:0]  PWD_WORDS_X16  = 8'h04;
	localparam logic [7:0]  EXT_SIZE_X8    = 8'hFF;
	localparam logic [7:0]  EXT_SIZE_X16   = 8'h7F;
	// sw register offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h1;
	localparam logic [3:0] REG_DATA   = 4'h2;
	localparam logic [3:0] REG_PWLO   = 4'h3;
	localparam logic [3:0] REG_PWHI   = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_RDATA  = 4'h6;
	localparam logic [3:0] REG_PWRLO  = 4'h7;
	localparam logic [3:0] REG_PWRHI  = 4'h8;
	// operation codes written to CTRL[3:0]
	localparam logic [3:0] OP_ENTER    = 4'h1;
	localparam logic [3:0] OP_EXIT     = 4'h2;
	localparam logic [3:0] OP_PROGRAM  = 4'h3;
	localparam logic [3:0] OP_READ     = 4'h4;
	localparam logic [3:0] OP_CLEARALL = 4'h5;
	localparam logic [3:0] OP_PWPROG   = 4'h6;
	localparam logic [3:0] OP_PWREAD   = 4'h7;
	localparam logic [3:0] OP_UNLOCK   = 4'h8;
	localparam logic [3:0] OP_EXTEXIT  = 4'h9;
	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_WIDE_BIT = 4;
	localparam int CTRL_CODE_LSB = 8;
	// bus timing
	localparam int CLK_MHZ       = 50;
	localparam int BUS_CYC_NS    = 100;
	localparam int BUS_CYC_CLKS  = (BUS_CYC_NS * CLK_MHZ + 999) / 1000;
	localparam int UNLK_GAP_NS   = 1000;
	localparam int UNLK_GAP_CLKS = (UNLK_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] BUS_CYC_CNT  = 8'(BUS_CYC_CLKS);
	localparam logic [7:0] UNLK_GAP_CNT = 8'(UNLK_GAP_CLKS);
	// one bus cycle to the flash
	typedef struct packed {
		logic        wr;
		logic [23:0] addr;
		logic [15:0] data;
	} fbp_cyc_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_LOAD = 5'b00010,
		ST_ASRT = 5'b00100,
		ST_DONE = 5'b01000,
		ST_WAIT = 5'b10000
	} fbp_state_t;
endpackage

// ===== fbp_host_asserts.sv
// port assertions for the block protection host controller
`timescale 1ns/10ps
`default_nettype none
module fbp_host_asserts (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [3:0]  regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic [23:0] flashAddr,
	input wire logic [15:0] flashDqOut,
	input wire logic        flashDqOe,
	input wire logic [15:0] flashDqIn,
	input wire logic        flashCeN,
	input wire logic        flashWeN,
	input wire logic        flashOeN
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_rst; $fell(sys_rst) |-> flashCeN && flashWeN && flashOeN && !flashDqOe; endproperty
	a_rst: assert property (p_rst) else $error("pins active after reset");
	property p_rdz; !regRd |=> regRdata == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside its cycle");
	property p_we; $fell(flashWeN) |-> !flashWeN[*5] ##[1:2] flashWeN; endproperty
	a_we: assert property (p_we) else $error("write strobe width");
	property p_oe; $fell(flashOeN) |-> !flashOeN[*5] ##[1:2] flashOeN; endproperty
	a_oe: assert property (p_oe) else $error("read strobe width");
	property p_sel; !flashWeN || !flashOeN |-> !flashCeN; endproperty
	a_sel: assert property (p_sel) else $error("strobe without chip enable");
	property p_excl; !flashWeN |-> flashOeN; endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	property p_dq; flashDqOe |-> flashOeN; endproperty
	a_dq: assert property (p_dq) else $error("data bus contention");
	property p_hold; !flashWeN && !$past(flashWeN) |-> $stable(flashAddr) && $stable(flashDqOut);
	endproperty
	a_hold: assert property (p_hold) else $error("address or data moved in write");
	property p_cen; $fell(flashCeN) |-> ##[1:10] $rose(flashCeN); endproperty
	a_cen: assert property (p_cen) else $error("bus cycle too long");
	c_wr: cover property ($fell(flashWeN));
	c_rd: cover property ($fell(flashOeN));
	c_ctrl: cover property (regWr && regAddr == fbp_pkg::REG_CTRL);
endmodule
`default_nettype wire

// ===== fbp_flash_model.sv
// behavioural flash device answering block protection command sets
`timescale 1ns/10ps
`default_nettype none
module fbp_flash_model (
	input  wire logic        ceN,
	input  wire logic        weN,
	input  wire logic        oeN,
	input  wire logic [23:0] addr,
	input  wire logic [15:0] dqIn,
	input  wire logic [63:0] pwd,
	output var  logic [15:0] dqOut
);
	logic [255:0] nv_r = '1;
	logic [255:0] vb_r = '1;
	logic         lk_r = 1'b1;
	logic         pa_r = 1'b0;
	logic [7:0]   mode_r = 8'h00;
	logic [7:0]   h1_r = 8'h00;
	logic [7:0]   h2_r = 8'h00;
	logic [15:0]  last_r = 16'h0000;
	logic [15:0]  rv;
	logic [15:0]  lr_r = 16'hFFFF;
	logic [63:0]  ulB_r = '0;
	logic [63:0]  ulW_r = '0;
	logic         ulFast = 1'b0;
	int           ulN = -1;
	time          ulEnd = 0;
	// lock register layout is not modelled; this bit position is arbitrary
	localparam int PW_LOCK_BIT = 2;
	wire  [7:0]   d = dqIn[7:0];
	wire  [7:0]   b = addr[23:16];
	// no clock here: commands latch on the write strobe
	always @(negedge weN) begin
		// unlock width is told by the pair count, not by a pin
		if (mode_r == 8'h60 && h1_r == 8'h25 && d == 8'h03) begin
			ulN = 0;
			ulFast = ($time - ulEnd) < 64'd1000;
		end else if (ulN >= 0) begin
			if (d == 8'h29 && ((ulN == 4 && ulW_r == pwd) || ulN == 8)) begin
				if (!ulFast && (ulN == 4 || ulB_r == pwd)) lk_r = 1'b1;
				ulEnd = $time;
				ulN = -1;
			end else begin
				ulB_r[8*addr[2:0]+:8] = d;
				ulW_r[16*addr[1:0]+:16] = dqIn;
				ulN++;
			end
		end
		if (pa_r) begin
			if (mode_r == 8'h40) lr_r = lr_r & dqIn;
			if (mode_r == 8'hC0 && lk_r) nv_r[b] = 1'b0;
			if (mode_r == 8'hE0) vb_r[b] = d[0];
			if (mode_r == 8'h50) lk_r = 1'b0;
			pa_r = 1'b0;
		end else if (h1_r == 8'h80 && d == 8'h30 && mode_r == 8'hC0 && lk_r)
			nv_r = '1;
		else if (mode_r == 8'h00 && h2_r == 8'hAA && h1_r == 8'h55)
			mode_r = d;
		else if (h1_r == 8'h90 && d == 8'h00)
			mode_r = 8'h00;
		else if (d == 8'hA0 && mode_r != 8'h00)
			pa_r = 1'b1;
		h2_r = h1_r;
		h1_r = d;
	end
	assign rv = mode_r == 8'h60 ? (lr_r[PW_LOCK_BIT] ? {8'h00, pwd[8*addr[2:0]+:8]}
		: 16'h00FF) :
		mode_r == 8'h40 ? lr_r :
		mode_r == 8'h88 ? {8'h00, ~addr[7:0]} :
		mode_r == 8'hC0 ? {15'h0, nv_r[b]} :
		mode_r == 8'hE0 ? {15'h0, vb_r[b]} :
		mode_r == 8'h50 ? {15'h0, lk_r} : 16'hFFFF;
	// released bus shows the inverse so stale data never passes
	always @(posedge oeN) last_r = rv;
	assign dqOut = (!ceN && !oeN) ? rv : ~last_r;
endmodule
`default_nettype wire

// ===== fbp_host_test.sv
// self-checking bench for the block protection host controller
`timescale 1ns/10ps
`default_nettype none
module fbp_host_test;
	logic              mclk = 0;
	logic              sys_rst = 1;
	logic              regWr = 0;
	logic              regRd = 0;
	logic              rdSeen = 0;
	logic [3:0]        regAddr = '0;
	logic [31:0]       regWdata = '0;
	logic [63:0]       pwd = '1;
	logic [7:0]        blk = '0;
	wire  [31:0]       regRdata;
	wire  [23:0]       fAddr;
	wire  [15:0]       dqOut, dqDev, dqBus;
	wire               dqOe, ceN, weN, oeN;
	int                err_count = 0;
	int                num_checks = 0;
	logic [32:0]       expRd[$];
	fbp_pkg::fbp_cyc_t expCyc[$];
	assign dqBus = dqOe ? dqOut : dqDev;
	always #10 mclk = ~mclk;
	fbp_host u_dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashAddr(fAddr),
		.flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqBus), .flashCeN(ceN),
		.flashWeN(weN), .flashOeN(oeN));
	fbp_flash_model u_flash (.ceN(ceN), .weN(weN), .oeN(oeN), .addr(fAddr), .dqIn(dqBus),
		.pwd(pwd), .dqOut(dqDev));
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic bad(string m);
		err_count++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic chkRd(logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) bad($sformatf("read %h want %h", g, e));
	endtask
	task automatic chkCyc(fbp_pkg::fbp_cyc_t e, logic [23:0] a, logic [15:0] d);
		num_checks++;
		if ((e.addr !== 24'hFFFFFF && a !== e.addr) || d[7:0] !== e.data[7:0]
			|| (e.data[15:8] != 8'h00 && d !== e.data))
			bad($sformatf("cycle %h/%h want %h/%h", a, d, e.addr, e.data));
	endtask
	always @(posedge mclk) begin : rdMon
		logic [32:0] n;
		if (rdSeen) begin
			n = expRd.pop_front();
			if (n[32]) chkRd(n[31:0], regRdata);
		end
		rdSeen <= regRd;
	end
	always @(negedge weN) begin
		if (expCyc.size() == 0) bad("unexpected flash write");
		else chkCyc(expCyc.pop_front(), fAddr, dqOut);
	end
	task automatic ex(logic [23:0] a, logic [15:0] d);
		expCyc.push_back('{1'b1, a, d});
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, logic c, logic [31:0] e);
		expRd.push_back({c, e});
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
	endtask
	// busy is polled, never waited on blindly
	task automatic op(logic [3:0] o, logic w, logic [7:0] c);
		int i;
		wr(fbp_pkg::REG_CTRL, {16'h0, c, 3'h0, w, o});
		for (i = 0; i < 400; i++) begin
			rd(fbp_pkg::REG_STATUS, 1'b0, 32'h0);
			@(negedge mclk);
			if (regRdata[0] === 1'b0) break;
		end
	endtask
	task automatic ent(logic [7:0] c);
		ex(24'h000AAA, 16'h00AA);
		ex(24'h000555, 16'h0055);
		ex(24'h000AAA, {8'h00, c});
		op(fbp_pkg::OP_ENTER, 1'b0, c);
	endtask
	task automatic xit;
		ex(24'hFFFFFF, 16'h0090);
		ex(24'hFFFFFF, 16'h0000);
		op(fbp_pkg::OP_EXIT, 1'b0, 8'h00);
	endtask
	task automatic unlk(logic w);
		int i;
		ex(24'h0, 16'h0025);
		ex(24'h0, 16'h0003);
		for (i = 0; i < (w ? 4 : 8); i++)
			ex(24'(i), w ? pwd[16*i+:16] : {8'h00, pwd[8*i+:8]});
		ex(24'h0, 16'h0029);
		op(fbp_pkg::OP_UNLOCK, w, 8'h00);
	endtask
	task automatic prog(logic [7:0] d);
		wr(fbp_pkg::REG_ADDR, {8'h00, blk, 16'h0});
		wr(fbp_pkg::REG_DATA, {24'h0, d});
		ex(24'hFFFFFF, 16'h00A0);
		ex({blk, 16'h0}, {8'h00, d});
		op(fbp_pkg::OP_PROGRAM, 1'b0, 8'h00);
	endtask
	task automatic chkBlk(logic [7:0] b, logic [31:0] e);
		wr(fbp_pkg::REG_ADDR, {8'h00, b, 16'h0});
		op(fbp_pkg::OP_READ, 1'b0, 8'h00);
		rd(fbp_pkg::REG_RDATA, 1'b1, e);
	endtask
	task automatic pwp;
		int i;
		for (i = 0; i < 8; i++) begin
			wr(fbp_pkg::REG_ADDR, 32'(i));
			wr(fbp_pkg::REG_DATA, {24'h0, pwd[8*i+:8]});
			ex(24'hFFFFFF, 16'h00A0);
			ex(24'(i), {8'h00, pwd[8*i+:8]});
			op(fbp_pkg::OP_PWPROG, 1'b0, 8'h00);
		end
	endtask
	initial begin
		void'($urandom(32'h0262));
		pwd = {$urandom(), $urandom()};
		blk = 8'($urandom());
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(fbp_pkg::REG_STATUS, 1'b1, 32'h0);
		rd(4'hF, 1'b1, 32'h0);
		rd(fbp_pkg::REG_PWLO, 1'b1, 32'hFFFFFFFF);
		ent(8'h60);
		op(fbp_pkg::OP_PWREAD, 1'b0, 8'h00);
		rd(fbp_pkg::REG_PWRLO, 1'b1, pwd[31:0]);
		rd(fbp_pkg::REG_PWRHI, 1'b1, pwd[63:32]);
		pwp();
		wr(fbp_pkg::REG_PWLO, pwd[31:0]);
		wr(fbp_pkg::REG_PWHI, pwd[63:32]);
		unlk(1'b0);
		op(fbp_pkg::OP_UNLOCK, 1'b0, 8'h00);
		rd(fbp_pkg::REG_STATUS, 1'b1, 32'h2);
		repeat (60) @(posedge mclk);
		unlk(1'b1);
		xit();
		ent(8'hC0);
		prog(8'h00);
		chkBlk(blk, 32'h0);
		chkBlk(blk + 8'h01, 32'h1);
		xit();
		ent(8'hE0);
		prog(8'h00);
		chkBlk(blk, 32'h0);
		prog(8'h01);
		chkBlk(blk, 32'h1);
		xit();
		ent(8'hC0);
		chkBlk(blk, 32'h0);
		xit();
		ent(8'h50);
		prog(8'h00);
		chkBlk(blk, 32'h0);
		xit();
		ent(8'hC0);
		ex(24'hFFFFFF, 16'h0080);
		ex(24'hFFFFFF, 16'h0030);
		op(fbp_pkg::OP_CLEARALL, 1'b0, 8'h00);
		chkBlk(blk, 32'h0);
		xit();
		ent(8'h60);
		unlk(1'b0);
		repeat (60) @(posedge mclk);
		xit();
		ent(8'h50);
		chkBlk(blk, 32'h1);
		xit();
		ent(8'hC0);
		ex(24'hFFFFFF, 16'h0080);
		ex(24'hFFFFFF, 16'h0030);
		op(fbp_pkg::OP_CLEARALL, 1'b0, 8'h00);
		chkBlk(blk, 32'h1);
		xit();
		wr(fbp_pkg::REG_ADDR, 32'h5);
		op(fbp_pkg::OP_READ, 1'b0, 8'h00);
		rd(fbp_pkg::REG_RDATA, 1'b1, 32'hFFFF);
		ent(8'h88);
		op(fbp_pkg::OP_READ, 1'b0, 8'h00);
		rd(fbp_pkg::REG_RDATA, 1'b1, 32'hFA);
		ex(24'h000AAA, 16'h00AA);
		ex(24'h000555, 16'h0055);
		ex(24'h000AAA, 16'h0090);
		ex(24'hFFFFFF, 16'h0000);
		op(fbp_pkg::OP_EXTEXIT, 1'b0, 8'h00);
		ent(8'h40);
		prog(8'hFB);
		chkBlk(blk, 32'hFB);
		xit();
		ent(8'h60);
		op(fbp_pkg::OP_PWREAD, 1'b0, 8'h00);
		rd(fbp_pkg::REG_PWRLO, 1'b1, 32'hFFFFFFFF);
		rd(fbp_pkg::REG_PWRHI, 1'b1, 32'hFFFFFFFF);
		xit();
		if (expCyc.size() != 0) bad("flash writes missing");
		close_out();
	end
	initial begin
		repeat (30000) @(posedge mclk);
		bad("timeout");
		close_out();
	end
endmodule
bind fbp_host fbp_host_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
	.flashDqIn(flashDqIn), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN));
`default_nettype wire
